/* File: rtl/aec_pkg.sv */
// Package of constants and types for the acoustic canceler control and pad register block
package aec_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] AEC_OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] AEC_OFF_MODE = 8'h09;
  localparam logic [7:0] AEC_OFF_TONE_CMD = 8'h0A;
  localparam logic [7:0] AEC_OFF_TX_PAD = 8'h0B;
  localparam logic [7:0] AEC_OFF_RX_PAD = 8'h0C;
  localparam logic [7:0] AEC_OFF_ST_ADDR_HI = 8'h0D;
  localparam logic [7:0] AEC_OFF_ST_ADDR_LO = 8'h0E;
  localparam logic [7:0] AEC_OFF_ST_DATA_HI = 8'h0F;
  localparam logic [7:0] AEC_OFF_ST_DATA_LO = 8'h10;
  localparam logic [7:0] AEC_OFF_STATUS = 8'h11;
  localparam logic [7:0] AEC_OFF_ST_RD_HI = 8'h12;
  localparam logic [7:0] AEC_OFF_ST_RD_LO = 8'h13;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] AEC_RST_MODE = 8'h80;
  localparam logic [7:0] AEC_RST_ZERO = 8'h00;
  localparam int AEC_STORE_WR_BIT = 4;
  localparam int AEC_PAD_LOSS_MSB = 7;
  localparam int AEC_PAD_LOSS_LSB = 5;
  localparam int AEC_PAD_GAIN_MSB = 4;
  localparam int AEC_PAD_GAIN_LSB = 2;
  localparam logic [7:0] AEC_PAD_MASK = 8'hFC;
  localparam int AEC_OPMODE_MSB = 3;
  localparam logic [3:0] AEC_INITIAL_MODE = 4'h0;
  localparam int AEC_STAT_HOWL_BIT = 0;
  localparam int AEC_STAT_REFUSED_BIT = 1;

  // ----------------------------------------------------------------
  // Store memory and signal levels
  // ----------------------------------------------------------------
  localparam int AEC_STORE_AW = 9;
  localparam int AEC_STORE_DEPTH = 512;
  localparam logic [7:0] AEC_MULAW_MIN_POS = 8'hFF;
  localparam logic [15:0] AEC_MULAW_CLAMP = 16'h7F7B;
  localparam logic [15:0] AEC_MULAW_BIAS = 16'h0084;
  localparam logic [15:0] AEC_CLIP_LEVEL = 16'h002E;
  localparam logic [15:0] AEC_ACT_LEVEL = 16'h0100;
  localparam logic [15:0] AEC_AGC_LEVEL = 16'h0800;
  localparam logic [15:0] AEC_HOWL_LEVEL = 16'h4000;
  localparam logic [7:0] AEC_HOWL_SAMPLES = 8'hC8;
  localparam logic [15:0] AEC_STEP1 = 16'h0010;
  localparam logic [15:0] AEC_STEP2 = 16'h0002;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic acoustic_through_mode;
    logic acoustic_coef1_clear;
    logic acoustic_coef2_clear;
    logic acoustic_howling_detect_on;
    logic acoustic_center_clip_on;
    logic acoustic_coef_freeze;
    logic acoustic_attenuator_off;
    logic acoustic_gain_control_on;
  } aec_mode_s;

  typedef struct packed {
    logic [7:0] receive;
    logic [7:0] send;
  } aec_pcm_s;

endpackage : aec_pkg

/* File: rtl/aec_regs.sv */
// Acoustic canceler mode, pad control and default store registers with the sample path they steer
`timescale 1ns/1ps

// Functional notes
// - Through bit bypasses cancellation, keeps coefficients
// - Bit 6 clears first coefficient set
// - Bit 5 clears second coefficient set
// - Bit 4 enables howling detector
// - Center clip forces minimum positive code
// - Bit 2 freezes coefficient updating
// - Attenuator about 6 dB, selected by activity
// - Bit 0 enables receive automatic gain control
// - Store write copies data to address
// - Transmit loss 0 to -14 dB, 2 dB
// - Transmit gain 0 to 14 dB, 2 dB
// - Receive loss 0 to -14 dB, 2 dB
// - Receive gain 0 to 14 dB, 2 dB
// - No 8-bit 64 kbps data mode
// - Mode switch may drop few samples
// - Through mode turns 7F into FF
module aec_regs
  import aec_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic pcm_valid_in,
  input wire aec_pcm_s pcm_in,
  output logic pcm_valid_out,
  output aec_pcm_s pcm_out,
  output logic howling_out
);

  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] mulaw_dec(input logic [7:0] code);
    logic [7:0] x;
    logic [15:0] mag;
    x = ~code;
    mag = 16'((16'({x[3:0], 3'b000}) + AEC_MULAW_BIAS) << x[6:4]);
    mag = mag - AEC_MULAW_BIAS;
    return x[7] ? -$signed(mag) : $signed(mag);
  endfunction : mulaw_dec

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    return v[15] ? 16'(-v) : 16'(v);
  endfunction : mag16

  function automatic logic [7:0] mulaw_enc(input logic signed [15:0] v);
    logic [15:0] mag;
    logic [2:0] ex;
    logic [3:0] mt;
    mag = mag16(v);
    ex = 3'h0;
    mag = ((mag > AEC_MULAW_CLAMP) ? AEC_MULAW_CLAMP : mag) + AEC_MULAW_BIAS;
    for (int i = 0; i < 8; i++)
    begin
      ex = mag[i + 7] ? 3'(i) : ex;
    end
    mt = 4'(mag >> ({1'b0, ex} + 4'h3));
    return ~{v[15], ex, mt};
  endfunction : mulaw_enc

  function automatic logic signed [15:0] sat16(input logic signed [19:0] v);
    return (v > 20'sh07FFF) ? 16'sh7FFF : (v < -20'sh08000) ? -16'sh8000 : 16'(v);
  endfunction : sat16

  // Factors in Q12, one entry per 2 dB step
  function automatic logic [15:0] loss_factor(input logic [2:0] code);
    unique case (code)
      3'h0: return 16'h1000;
      3'h1: return 16'h0CB6;
      3'h2: return 16'h0A18;
      3'h3: return 16'h0805;
      3'h4: return 16'h065F;
      3'h5: return 16'h050F;
      3'h6: return 16'h0405;
      3'h7: return 16'h0331;
    endcase
  endfunction : loss_factor

  function automatic logic [15:0] gain_factor(input logic [2:0] code);
    unique case (code)
      3'h0: return 16'h1000;
      3'h1: return 16'h1425;
      3'h2: return 16'h195C;
      3'h3: return 16'h1FED;
      3'h4: return 16'h2831;
      3'h5: return 16'h3299;
      3'h6: return 16'h3FB2;
      3'h7: return 16'h5031;
    endcase
  endfunction : gain_factor

  // Loss first, then gain, saturating at each stage
  function automatic logic signed [15:0] pad(input logic signed [15:0] v, input logic [7:0] reg_val);
    logic signed [32:0] p;
    logic signed [15:0] s;
    p = v * $signed({1'b0, loss_factor(reg_val[AEC_PAD_LOSS_MSB:AEC_PAD_LOSS_LSB])});
    s = sat16(20'(p >>> 12));
    p = s * $signed({1'b0, gain_factor(reg_val[AEC_PAD_GAIN_MSB:AEC_PAD_GAIN_LSB])});
    return sat16(20'(p >>> 12));
  endfunction : pad

  function automatic logic signed [15:0] step_coef(input logic signed [15:0] c, input logic [15:0] step,
                                                   input logic down);
    return down ? sat16(20'(c) - 20'($signed(step))) : sat16(20'(c) + 20'($signed(step)));
  endfunction : step_coef

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] main_ctrl_ff;
  aec_mode_s mode_ff;
  logic [7:0] tx_pad_ff;
  logic [7:0] rx_pad_ff;
  logic [7:0] st_addr_hi_ff;
  logic [7:0] st_addr_lo_ff;
  logic [7:0] st_data_hi_ff;
  logic [7:0] st_data_lo_ff;
  logic store_refused_ff;
  logic howl_ff;
  logic [7:0] reg_rdata_ff;
  logic [15:0] store_mem [AEC_STORE_DEPTH];
  logic [15:0] st_addr;
  logic [AEC_STORE_AW-1:0] st_index;
  logic st_in_range;
  logic st_cmd;
  logic st_allowed;
  logic [7:0] nxt_rdata;

  assign st_addr = {st_addr_hi_ff, st_addr_lo_ff};
  assign st_index = st_addr[AEC_STORE_AW-1:0];
  assign st_in_range = (st_addr >> AEC_STORE_AW) == 16'h0000;
  assign st_cmd = reg_wr_in && (reg_addr_in == AEC_OFF_TONE_CMD) && reg_wdata_in[AEC_STORE_WR_BIT];
  // Store is only alterable in initial mode
  assign st_allowed = (main_ctrl_ff[AEC_OPMODE_MSB:0] == AEC_INITIAL_MODE) && st_in_range;

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      main_ctrl_ff <= AEC_RST_ZERO;
      mode_ff <= AEC_RST_MODE;
      tx_pad_ff <= AEC_RST_ZERO;
      rx_pad_ff <= AEC_RST_ZERO;
      st_addr_hi_ff <= AEC_RST_ZERO;
      st_addr_lo_ff <= AEC_RST_ZERO;
      st_data_hi_ff <= AEC_RST_ZERO;
      st_data_lo_ff <= AEC_RST_ZERO;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        AEC_OFF_MAIN_CTRL: main_ctrl_ff <= reg_wdata_in;
        AEC_OFF_MODE: mode_ff <= reg_wdata_in;
        AEC_OFF_TX_PAD: tx_pad_ff <= reg_wdata_in & AEC_PAD_MASK;
        AEC_OFF_RX_PAD: rx_pad_ff <= reg_wdata_in & AEC_PAD_MASK;
        AEC_OFF_ST_ADDR_HI: st_addr_hi_ff <= reg_wdata_in;
        AEC_OFF_ST_ADDR_LO: st_addr_lo_ff <= reg_wdata_in;
        AEC_OFF_ST_DATA_HI: st_data_hi_ff <= reg_wdata_in;
        AEC_OFF_ST_DATA_LO: st_data_lo_ff <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Command uses whatever the address and data registers hold now
  always_ff @(posedge clk_sys_in)
  begin
    if (st_cmd && st_allowed && rst_sync_ff)
    begin
      store_mem[st_index] <= {st_data_hi_ff, st_data_lo_ff};
    end
  end

  // A refused command stays visible until status is read; a new refusal wins
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      store_refused_ff <= 1'b0;
    end
    else if (st_cmd && !st_allowed)
    begin
      store_refused_ff <= 1'b1;
    end
    else if (reg_rd_in && (reg_addr_in == AEC_OFF_STATUS))
    begin
      store_refused_ff <= 1'b0;
    end
  end

  // Command bit self-clears and the reserved tone bits hold nothing, so the register reads zero
  always_comb
  begin
    nxt_rdata = AEC_RST_ZERO;
    unique case (reg_addr_in)
      AEC_OFF_MAIN_CTRL: nxt_rdata = main_ctrl_ff;
      AEC_OFF_MODE: nxt_rdata = mode_ff;
      AEC_OFF_TONE_CMD: nxt_rdata = AEC_RST_ZERO;
      AEC_OFF_TX_PAD: nxt_rdata = tx_pad_ff;
      AEC_OFF_RX_PAD: nxt_rdata = rx_pad_ff;
      AEC_OFF_ST_ADDR_HI: nxt_rdata = st_addr_hi_ff;
      AEC_OFF_ST_ADDR_LO: nxt_rdata = st_addr_lo_ff;
      AEC_OFF_ST_DATA_HI: nxt_rdata = st_data_hi_ff;
      AEC_OFF_ST_DATA_LO: nxt_rdata = st_data_lo_ff;
      AEC_OFF_STATUS: nxt_rdata = 8'({store_refused_ff, howl_ff});
      AEC_OFF_ST_RD_HI: nxt_rdata = st_in_range ? store_mem[st_index][15:8] : AEC_RST_ZERO;
      AEC_OFF_ST_RD_LO: nxt_rdata = st_in_range ? store_mem[st_index][7:0] : AEC_RST_ZERO;
      default: nxt_rdata = AEC_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      reg_rdata_ff <= AEC_RST_ZERO;
    end
    else
    begin
      reg_rdata_ff <= reg_rd_in ? nxt_rdata : AEC_RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  // Voice samples only; 8-bit wide data at 64 kbps has no path here
  logic signed [15:0] coef1_ff;
  logic signed [15:0] coef2_ff;
  logic [7:0] howl_cnt_ff;
  aec_pcm_s pcm_out_ff;
  logic pcm_valid_ff;
  logic signed [15:0] rin;
  logic signed [15:0] sin;
  logic signed [15:0] rin_agc;
  logic signed [16:0] coef_sum;
  logic signed [32:0] est_prod;
  logic signed [15:0] est;
  logic signed [15:0] err;
  logic signed [15:0] send_lin;
  logic signed [15:0] rx_lin;
  logic rx_active;
  logic tx_active;
  logic rx_loud;
  logic clip_hit;
  logic adapt;
  logic step_down;
  aec_pcm_s nxt_pcm;

  always_comb
  begin
    rin = mulaw_dec(pcm_in.receive);
    sin = mulaw_dec(pcm_in.send);
    rx_active = mag16(rin) > AEC_ACT_LEVEL;
    tx_active = mag16(sin) > AEC_ACT_LEVEL;
    rx_loud = mag16(rin) > AEC_HOWL_LEVEL;
    rin_agc = (mode_ff.acoustic_gain_control_on && (mag16(rin) > AEC_AGC_LEVEL)) ? rin - (rin >>> 2) : rin;
    coef_sum = 17'(coef1_ff) + 17'(coef2_ff);
    est_prod = coef_sum * rin_agc;
    est = sat16(20'(est_prod >>> 14));
    err = sat16(20'(sin) - 20'(est));
    // Switching modes takes effect on the next sample with no blending
    send_lin = mode_ff.acoustic_through_mode ? sin : err;
    rx_lin = mode_ff.acoustic_through_mode ? rin : rin_agc;
    if (!mode_ff.acoustic_through_mode && !mode_ff.acoustic_attenuator_off)
    begin
      send_lin = (rx_active && !tx_active) ? send_lin >>> 1 : send_lin;
      rx_lin = tx_active ? rx_lin >>> 1 : rx_lin;
    end
    clip_hit = !mode_ff.acoustic_through_mode && mode_ff.acoustic_center_clip_on
               && (mag16(send_lin) <= AEC_CLIP_LEVEL);
    // A decoded 7F is zero, which always encodes as FF
    nxt_pcm.send = clip_hit ? AEC_MULAW_MIN_POS : mulaw_enc(pad(send_lin, tx_pad_ff));
    nxt_pcm.receive = mulaw_enc(pad(rx_lin, rx_pad_ff));
    adapt = pcm_valid_in && rx_active && !howl_ff && !mode_ff.acoustic_through_mode
            && !mode_ff.acoustic_coef_freeze;
    step_down = err[15] ^ rin_agc[15];
  end

  // Clears act while the bit is high, with or without samples
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      coef1_ff <= 16'sh0000;
      coef2_ff <= 16'sh0000;
    end
    else
    begin
      coef1_ff <= mode_ff.acoustic_coef1_clear ? 16'sh0000
                  : (adapt ? step_coef(coef1_ff, AEC_STEP1, step_down) : coef1_ff);
      coef2_ff <= mode_ff.acoustic_coef2_clear ? 16'sh0000
                  : (adapt ? step_coef(coef2_ff, AEC_STEP2, step_down) : coef2_ff);
    end
  end

  // Sustained loud receive input marks howling and stops adaptation
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      howl_cnt_ff <= 8'h00;
      howl_ff <= 1'b0;
    end
    else if (!mode_ff.acoustic_howling_detect_on)
    begin
      howl_cnt_ff <= 8'h00;
      howl_ff <= 1'b0;
    end
    else if (pcm_valid_in)
    begin
      howl_cnt_ff <= !rx_loud ? 8'h00 : (howl_cnt_ff == AEC_HOWL_SAMPLES) ? howl_cnt_ff : howl_cnt_ff + 8'h01;
      howl_ff <= rx_loud && (howl_ff || (howl_cnt_ff == AEC_HOWL_SAMPLES - 8'h01));
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      pcm_out_ff <= {AEC_MULAW_MIN_POS, AEC_MULAW_MIN_POS};
      pcm_valid_ff <= 1'b0;
    end
    else
    begin
      pcm_valid_ff <= pcm_valid_in;
      pcm_out_ff <= pcm_valid_in ? nxt_pcm : pcm_out_ff;
    end
  end

  assign reg_rdata_out = reg_rdata_ff;
  assign pcm_valid_out = pcm_valid_ff;
  assign pcm_out = pcm_out_ff;
  assign howling_out = howl_ff;
endmodule : aec_regs

/* File: verif/aec_regs_checker.sv */
// Concurrent checks on the ports of the canceler register block
`timescale 1ns/1ps
module aec_regs_checker
  import aec_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic pcm_valid_in,
  input wire aec_pcm_s pcm_in,
  input wire logic pcm_valid_out,
  input wire aec_pcm_s pcm_out,
  input wire logic howling_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------------------------------
  // Shadow state rebuilt from the bus
  // ----------------------------------------------------------------
  logic [7:0] mode_ff;
  logic [7:0] tx_ff;
  logic [7:0] rx_ff;
  logic [7:0] loud_ff;
  wire logic pads_zero = (tx_ff[7:2] == 6'h00) && (rx_ff[7:2] == 6'h00);
  // Top segment of a mu-law code is the only one above the howl level
  wire logic loud = (pcm_in.receive[6:4] == 3'h0);

  function automatic logic [7:0] fix(input logic [7:0] c);
    return (c == 8'h7F) ? 8'hFF : c;
  endfunction : fix

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mode_ff <= AEC_RST_MODE;
      tx_ff <= 8'h00;
      rx_ff <= 8'h00;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == AEC_OFF_MODE) mode_ff <= reg_wdata_in;
      if (reg_addr_in == AEC_OFF_TX_PAD) tx_ff <= reg_wdata_in;
      if (reg_addr_in == AEC_OFF_RX_PAD) rx_ff <= reg_wdata_in;
    end
  end

  // Saturates at the howl count so a long tone cannot wrap it
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in) loud_ff <= 8'h00;
    else if (!mode_ff[4]) loud_ff <= 8'h00;
    else if (pcm_valid_in) loud_ff <= !loud ? 8'h00 : (loud_ff == 8'hC8) ? 8'hC8 : loud_ff + 8'h01;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_rd(a);
    reg_rd_in && (reg_addr_in == a);
  endsequence
  sequence s_thru;
    pcm_valid_in && mode_ff[7] && pads_zero;
  endsequence

  property p_tone_zero; s_rd(AEC_OFF_TONE_CMD) |=> reg_rdata_out == 8'h00; endproperty
  property p_idle_zero; !reg_rd_in |=> reg_rdata_out == 8'h00; endproperty
  property p_tx_rb; s_rd(AEC_OFF_TX_PAD) |=> reg_rdata_out == (tx_ff & AEC_PAD_MASK); endproperty
  property p_rx_rb; s_rd(AEC_OFF_RX_PAD) |=> reg_rdata_out == (rx_ff & AEC_PAD_MASK); endproperty
  property p_mode_rb; s_rd(AEC_OFF_MODE) |=> reg_rdata_out == mode_ff; endproperty
  property p_thru_7f; s_thru ##0 (pcm_in.send == 8'h7F) |=> pcm_valid_out && pcm_out.send == 8'hFF; endproperty
  property p_thru_pass; s_thru |=> pcm_out.receive == fix($past(pcm_in.receive)); endproperty
  property p_clip;
    pcm_valid_in && !mode_ff[7] && mode_ff[3] && pads_zero && pcm_in == 16'hFFFE
      |=> pcm_out.send == AEC_MULAW_MIN_POS;
  endproperty
  property p_howl_set; pcm_valid_in && mode_ff[4] && loud && loud_ff == 8'hC7 |=> howling_out; endproperty
  property p_howl_rise; $rose(howling_out) |-> loud_ff == 8'hC8; endproperty

  a_tone_zero: assert property (p_tone_zero) else $error("tone register read not zero");
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside read slot");
  a_tx_rb: assert property (p_tx_rb) else $error("transmit pad readback wrong");
  a_rx_rb: assert property (p_rx_rb) else $error("receive pad readback wrong");
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  a_thru_7f: assert property (p_thru_7f) else $error("through mode kept 7F");
  a_thru_pass: assert property (p_thru_pass) else $error("through mode altered receive");
  a_clip: assert property (p_clip) else $error("center clip not applied");
  a_howl_set: assert property (p_howl_set) else $error("howling not flagged");
  a_howl_rise: assert property (p_howl_rise) else $error("howling flagged early");
endmodule : aec_regs_checker

bind aec_regs aec_regs_checker chk_u (.clk_sys_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .pcm_valid_in, .pcm_in, .pcm_valid_out, .pcm_out, .howling_out);

/* File: verif/aec_host_model.sv */
// Host controller model that drives the register bus
`timescale 1ns/1ps
module aec_host_model
  import aec_pkg::*;
(
  input wire logic clk_sys_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'h0;
    reg_rd_out = 1'h0;
  end

  task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys_in);
    reg_addr_out <= addr;
    reg_wdata_out <= data;
    reg_wr_out <= 1'h1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'h0;
    // Released data lines show no stale value
    reg_wdata_out <= ~data;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys_in);
    reg_addr_out <= addr;
    reg_rd_out <= 1'h1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'h0;
    #1;
    data = reg_rdata_in;
  endtask : rd_reg

  task automatic store_write(input logic [15:0] addr, input logic [15:0] data);
    wr_reg(AEC_OFF_MAIN_CTRL, 8'h00);
    wr_reg(AEC_OFF_ST_ADDR_HI, addr[15:8]);
    wr_reg(AEC_OFF_ST_ADDR_LO, addr[7:0]);
    wr_reg(AEC_OFF_ST_DATA_HI, data[15:8]);
    wr_reg(AEC_OFF_ST_DATA_LO, data[7:0]);
    wr_reg(AEC_OFF_TONE_CMD, 8'h10);
  endtask : store_write

  task automatic clear_coefs(input logic [7:0] mode);
    wr_reg(AEC_OFF_MODE, mode | 8'h60);
    wr_reg(AEC_OFF_MODE, mode);
  endtask : clear_coefs
endmodule : aec_host_model

/* File: verif/aec_regs_tb_top.sv */
// Self-checking bench for the canceler register block
`timescale 1ns/1ps
module aec_regs_tb_top
  import aec_pkg::*;
;
  logic clk_sys_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic pcm_valid_in = 1'h0;
  aec_pcm_s pcm_in = 16'hFFFF;
  logic pcm_valid_out;
  aec_pcm_s pcm_out;
  logic howling_out;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] rdv;

  always #5 clk_sys_in = ~clk_sys_in;

  aec_regs dut_u (.clk_sys_in, .arst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .pcm_valid_in, .pcm_in, .pcm_valid_out, .pcm_out, .howling_out);
  aec_host_model host_u (.clk_sys_in, .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_rdata_in(reg_rdata_out));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
    host_u.rd_reg(addr, rdv);
    check({8'h00, rdv}, exp);
  endtask : rd_chk

  // Voice samples only; the block has no 8-bit data mode
  task automatic sample(input logic [7:0] rx, input logic [7:0] sx);
    @(posedge clk_sys_in);
    pcm_valid_in <= 1'h1;
    pcm_in <= {rx, sx};
    @(posedge clk_sys_in);
    pcm_valid_in <= 1'h0;
    #1;
    check({15'h0, pcm_valid_out}, 16'h0001);
  endtask : sample

  task automatic results();
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Cuts a hang short well above the expected run length
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    arst_n_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    rd_chk(AEC_OFF_MODE, 16'h0080);
    for (int i = 0; i < 7; i++)
      rd_chk(AEC_OFF_TONE_CMD + 8'(i), 16'h0000);
    rd_chk(8'hFF, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      host_u.wr_reg(AEC_OFF_TX_PAD, {3'(i), 3'(7 - i), 2'h3});
      host_u.wr_reg(AEC_OFF_RX_PAD, {3'(7 - i), 3'(i), 2'h3});
      rd_chk(AEC_OFF_TX_PAD, {8'h00, 3'(i), 3'(7 - i), 2'h0});
      rd_chk(AEC_OFF_RX_PAD, {8'h00, 3'(7 - i), 3'(i), 2'h0});
      host_u.wr_reg(AEC_OFF_MODE, 8'(1 << i));
      rd_chk(AEC_OFF_MODE, 16'(1 << i));
    end
    host_u.wr_reg(AEC_OFF_TX_PAD, 8'h00);
    host_u.wr_reg(AEC_OFF_RX_PAD, 8'h00);
    host_u.wr_reg(AEC_OFF_TONE_CMD, 8'hEF);
    rd_chk(AEC_OFF_TONE_CMD, 16'h0000);
    host_u.clear_coefs(8'h80);
    sample(8'h7F, 8'h7F);
    check(pcm_out, 16'hFFFF);
    sample(8'h12, 8'h80);
    check(pcm_out, 16'h1280);
    host_u.wr_reg(AEC_OFF_MODE, 8'h08);
    sample(8'hFF, 8'hFE);
    check({8'h00, pcm_out.send}, 16'h00FF);
    host_u.wr_reg(AEC_OFF_MODE, 8'h00);
    sample(8'hFF, 8'hFE);
    check({8'h00, pcm_out.send}, 16'h00FE);
    host_u.wr_reg(AEC_OFF_MODE, 8'h60);
    sample(8'h80, 8'hF0);
    check(pcm_out, 16'h80F7);
    host_u.wr_reg(AEC_OFF_MODE, 8'h62);
    sample(8'h80, 8'hF0);
    check(pcm_out, 16'h80F0);
    host_u.wr_reg(AEC_OFF_MODE, 8'h63);
    sample(8'h80, 8'hF0);
    check(pcm_out, 16'h88F0);
    host_u.wr_reg(AEC_OFF_MODE, 8'h10);
    repeat (199) sample(8'h80, 8'hFF);
    check({15'h0, howling_out}, 16'h0000);
    sample(8'h80, 8'hFF);
    check({15'h0, howling_out}, 16'h0001);
    rd_chk(AEC_OFF_STATUS, 16'h0001);
    sample(8'hFF, 8'hFF);
    check({15'h0, howling_out}, 16'h0000);
    host_u.wr_reg(AEC_OFF_MODE, 8'h00);
    repeat (200) sample(8'h80, 8'hFF);
    check({15'h0, howling_out}, 16'h0000);
    host_u.store_write(16'h0123, 16'hABCD);
    rd_chk(AEC_OFF_ST_RD_HI, 16'h00AB);
    rd_chk(AEC_OFF_ST_RD_LO, 16'h00CD);
    host_u.wr_reg(AEC_OFF_MAIN_CTRL, 8'h01);
    host_u.wr_reg(AEC_OFF_ST_DATA_HI, 8'h55);
    host_u.wr_reg(AEC_OFF_TONE_CMD, 8'h10);
    rd_chk(AEC_OFF_STATUS, 16'h0002);
    rd_chk(AEC_OFF_STATUS, 16'h0000);
    rd_chk(AEC_OFF_ST_RD_HI, 16'h00AB);
    results();
  end
endmodule : aec_regs_tb_top
